// [hdl/epp_ecp_parallel_port.sv]
`timescale 1ns/1ps
module byte_fifo
  import epp_ecp_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = FIFO_DEPTH
)(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      wr_next;
  logic [AW:0]      rd_reg;
  logic [AW:0]      rd_next;
  logic             push;
  logic             pop;

  assign out_valid = (wr_reg != rd_reg);
  assign in_ready  = (wr_reg[AW-1:0] != rd_reg[AW-1:0]) || (wr_reg[AW] == rd_reg[AW]);
  assign out_data  = mem[rd_reg[AW-1:0]];
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_valid && out_ready && !flush;

  always_comb
  begin
    wr_next = wr_reg;
    rd_next = rd_reg;
    if (flush)
    begin
      wr_next = '0;
      rd_next = '0;
    end
    else
    begin
      if (push)
        wr_next = wr_reg + 1'b1;
      if (pop)
        rd_next = rd_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
    end
    else
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  // Storage has no reset; only pointers carry state
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_reg[AW-1:0]] <= in_data;
  end
endmodule // byte_fifo

////////////////////////////////////////////////////////////////////////////////
module epp_ecp_parallel_port
  import epp_ecp_pkg::*;
#(
  parameter int TIMEOUT = TIMEOUT_CYC
)(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       epp_enable,
  input  wire host_req_t  host_req,
  input  wire logic       internal_read_strobe,
  input  wire logic       internal_write_strobe,
  output logic [7:0]      rdata_reg,
  output logic            done_reg,
  input  wire logic [7:0] pd_in,
  output logic [7:0]      pd_out_reg,
  output logic            pd_oe_n,
  input  wire pins_t      pins_in,
  output logic            host_strobe_pin,
  output logic            auto_feed_pin,
  output logic            select_in_pin,
  output logic            reverse_request_out
);
  // Two-stage synchronisers on every pin input
  pins_t      pin_meta_reg;
  pins_t      pin_reg;
  logic [7:0] pd_meta_reg;
  logic [7:0] pd_reg;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_meta_reg <= '0;
      pin_reg      <= '0;
      pd_meta_reg  <= '0;
      pd_reg       <= '0;
    end
    else
    begin
      pin_meta_reg <= pins_in;
      pin_reg      <= pin_meta_reg;
      pd_meta_reg  <= pd_in;
      pd_reg       <= pd_meta_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  logic [2:0]  mode_reg, mode_next;
  logic [2:0]  ectl_reg, ectl_next;
  logic [5:0]  dcr_reg, dcr_next;
  logic [7:0]  data_reg, data_next;
  logic [7:0]  last_reg, last_next;
  logic        cycle_timeout_flag_reg, cycle_timeout_flag_next;
  logic        rd_q_reg, wr_q_reg;
  logic [7:0]  rdata_next;
  logic        done_next;
  epp_state_t  epp_reg, epp_next;
  logic        epp_wr_reg, epp_wr_next;
  logic        epp_addr_reg, epp_addr_next;
  logic [31:0] epp_cnt_reg, epp_cnt_next;
  ecp_state_t  ecp_reg, ecp_next;
  fifo_word_t  cur_reg, cur_next;
  logic [7:0]  rle_reg, rle_next;
  logic        rd_rise, wr_rise, dir_eff, fifo_loc, epp_loc, timed_out;
  logic        f_in_valid, f_in_ready, f_out_valid, f_out_ready, flush;
  fifo_word_t  f_in_data, f_out_data;
  logic        host_push, host_pop;

  assign rd_rise  = internal_read_strobe && !rd_q_reg;
  assign wr_rise  = internal_write_strobe && !wr_q_reg;
  // Direction forced forward where only forward transfers exist
  assign dir_eff  = (mode_reg == MODE_SPP || mode_reg == MODE_FIFO) ? 1'b0
                    : dcr_reg[DCR_DIR]; // RULE_24
  assign fifo_loc = (host_req.base2 && host_req.offset == OFF_DATA
                     && (mode_reg == MODE_FIFO || mode_reg == MODE_ECP
                         || mode_reg == MODE_TEST))
                    || (!host_req.base2 && host_req.offset == OFF_DATA
                        && mode_reg == MODE_ECP);
  assign epp_loc  = epp_enable && !host_req.base2 && host_req.offset >= OFF_EPP_ADDR;
  assign timed_out = (epp_cnt_reg >= 32'(TIMEOUT - 1));
  assign flush    = (mode_reg == MODE_SPP); // RULE_14

  assign host_push = wr_rise && fifo_loc && epp_reg == EPP_IDLE;
  assign host_pop  = rd_rise && fifo_loc && host_req.base2 && f_out_valid
                     && (mode_reg == MODE_TEST || (mode_reg == MODE_ECP && dir_eff));

  //////////////////////////////////////////////////////////////////////////////
  // Host access and EPP handshake
  always_comb
  begin
    mode_next     = mode_reg;
    ectl_next     = ectl_reg;
    dcr_next      = dcr_reg;
    data_next     = data_reg;
    last_next     = last_reg;
    cycle_timeout_flag_next    = cycle_timeout_flag_reg;
    rdata_next    = rdata_reg;
    done_next     = 1'b0;
    epp_next      = epp_reg;
    epp_wr_next   = epp_wr_reg;
    epp_addr_next = epp_addr_reg;
    epp_cnt_next  = 32'h0000_0000;
    if (host_pop)
      last_next = f_out_data.data;
    case (epp_reg)
      EPP_IDLE:
      begin
        if ((rd_rise || wr_rise) && epp_loc)
        begin
          epp_next      = EPP_STROBE; // RULE_01 RULE_05 RULE_08
          epp_wr_next   = wr_rise;
          epp_addr_next = (host_req.offset == OFF_EPP_ADDR);
          if (wr_rise)
            data_next = host_req.wdata; // RULE_04
        end
        else if (wr_rise)
        begin
          done_next = 1'b1;
          if (!host_req.base2)
          begin
            case (host_req.offset)
              OFF_DATA:    if (!fifo_loc) data_next = host_req.wdata;
              OFF_STATUS:  if (host_req.wdata[0]) cycle_timeout_flag_next = 1'b0;
              OFF_CONTROL: dcr_next = host_req.wdata[5:0];
              default:     data_next = data_reg;
            endcase
          end
          else if (host_req.offset == OFF_CONTROL)
          begin
            mode_next = host_req.wdata[7:ECR_MODE_LSB]; // RULE_25
            ectl_next = host_req.wdata[4:2];
          end
        end
        else if (rd_rise)
        begin
          done_next = 1'b1;
          if (!host_req.base2)
          begin
            case (host_req.offset)
              OFF_DATA:
                rdata_next = (mode_reg == MODE_PS2 && dir_eff) ? pd_reg : data_reg;
              OFF_STATUS:
                rdata_next = {!pin_reg.busy, pin_reg.ack_n, pin_reg.perror,
                              pin_reg.select, pin_reg.fault_n, 2'b11,
                              cycle_timeout_flag_reg || !epp_enable};
              OFF_CONTROL:
                rdata_next = {2'b11, dcr_reg};
              default:
                rdata_next = 8'hFF;
            endcase
          end
          else
          begin
            case (host_req.offset)
              OFF_DATA:
                rdata_next = (mode_reg == MODE_CFG) ? CAPA_VALUE
                             : (host_pop ? f_out_data.data : last_reg);
              OFF_STATUS:
                rdata_next = (mode_reg == MODE_CFG) ? CAPB_VALUE : 8'hFF; // RULE_12
              OFF_CONTROL:
                rdata_next = {mode_reg, ectl_reg, !f_in_ready, !f_out_valid}; // RULE_15 RULE_26
              default:
                rdata_next = 8'hFF;
            endcase
          end
        end
      end
      EPP_STROBE:
      begin
        epp_cnt_next = epp_cnt_reg + 32'h0000_0001;
        if (pin_reg.busy)
        begin
          epp_next = EPP_END; // RULE_02 RULE_06 RULE_09
          if (!epp_wr_reg)
            rdata_next = pd_reg;
          done_next = 1'b1;
        end
        else if (timed_out)
        begin
          epp_next   = EPP_IDLE; // RULE_23
          cycle_timeout_flag_next = 1'b1;
          done_next  = 1'b1;
        end
      end
      EPP_END:
      begin
        epp_cnt_next = epp_cnt_reg + 32'h0000_0001;
        if (!pin_reg.busy)
          epp_next = EPP_IDLE; // RULE_07 RULE_03 RULE_10
        else if (timed_out)
        begin
          epp_next   = EPP_IDLE; // RULE_23
          cycle_timeout_flag_next = 1'b1;
        end
      end
      default:
        epp_next = EPP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_reg     <= ECR_MODE_RST;
      ectl_reg     <= ECR_CTRL_RST;
      dcr_reg      <= DCR_RESET;
      data_reg     <= DATA_RESET;
      last_reg     <= DATA_RESET;
      cycle_timeout_flag_reg    <= 1'b0;
      rd_q_reg     <= 1'b0;
      wr_q_reg     <= 1'b0;
      rdata_reg    <= 8'h00;
      done_reg     <= 1'b0;
      epp_reg      <= EPP_IDLE;
      epp_wr_reg   <= 1'b0;
      epp_addr_reg <= 1'b0;
      epp_cnt_reg  <= 32'h0000_0000;
    end
    else
    begin
      mode_reg     <= mode_next;
      ectl_reg     <= ectl_next;
      dcr_reg      <= dcr_next;
      data_reg     <= data_next;
      last_reg     <= last_next;
      cycle_timeout_flag_reg    <= cycle_timeout_flag_next;
      rd_q_reg     <= internal_read_strobe;
      wr_q_reg     <= internal_write_strobe;
      rdata_reg    <= rdata_next;
      done_reg     <= done_next;
      epp_reg      <= epp_next;
      epp_wr_reg   <= epp_wr_next;
      epp_addr_reg <= epp_addr_next;
      epp_cnt_reg  <= epp_cnt_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Extended capabilities engine; reverse counts stall on a full FIFO
  always_comb
  begin
    ecp_next    = ecp_reg;
    cur_next    = cur_reg;
    rle_next    = rle_reg;
    f_out_ready = host_pop;
    f_in_valid  = host_push;
    f_in_data   = '{tag: !host_req.base2, data: host_req.wdata}; // RULE_13
    case (ecp_reg)
      ECP_IDLE:
      begin
        if (mode_reg == MODE_ECP && !dir_eff && f_out_valid)
        begin
          ecp_next    = ECP_FWD_STB; // RULE_18
          cur_next    = f_out_data;
          f_out_ready = 1'b1;
        end
        else if (mode_reg == MODE_ECP && dir_eff && !pin_reg.perror)
          ecp_next = ECP_REV_REQ; // RULE_17
      end
      ECP_FWD_STB:
        if (pin_reg.busy)
          ecp_next = ECP_FWD_WAIT; // RULE_18
      ECP_FWD_WAIT:
        if (!pin_reg.busy)
          ecp_next = ECP_IDLE;
      ECP_REV_REQ:
        if (!pin_reg.ack_n)
        begin
          ecp_next = ECP_REV_ACK;
          cur_next = '{tag: !pin_reg.busy, data: pd_reg};
        end
      ECP_REV_ACK:
        if (pin_reg.ack_n)
        begin
          if (cur_reg.tag && !cur_reg.data[7])
          begin
            rle_next = {1'b0, cur_reg.data[6:0]}; // RULE_12
            ecp_next = ECP_IDLE;
          end
          else
            ecp_next = ECP_REV_PUSH;
        end
      ECP_REV_PUSH:
      begin
        f_in_valid = 1'b1;
        f_in_data  = cur_reg;
        if (f_in_ready)
        begin
          if (rle_reg == 8'h00)
            ecp_next = ECP_IDLE;
          else
            rle_next = rle_reg - 8'h01; // RULE_12
        end
      end
      default:
        ecp_next = ECP_IDLE;
    endcase
    if (mode_reg != MODE_ECP && ecp_reg != ECP_REV_PUSH)
      ecp_next = ECP_IDLE;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ecp_reg <= ECP_IDLE;
      cur_reg <= '0;
      rle_reg <= 8'h00;
    end
    else
    begin
      ecp_reg <= ecp_next;
      cur_reg <= cur_next;
      rle_reg <= rle_next;
    end
  end

  byte_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .flush     (flush),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  ); // RULE_11

  //////////////////////////////////////////////////////////////////////////////
  // Pins; EPP cycle owns strobes, else engine or control register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pd_out_reg <= 8'h00;
    // Byte loads on the strobe's own edge so it never trails the strobe
    else if (ecp_next == ECP_FWD_STB)
      pd_out_reg <= cur_next.data;
    else if (mode_reg == MODE_TEST && host_pop)
      pd_out_reg <= f_out_data.data;
    else
      pd_out_reg <= data_next;
  end

  always_comb
  begin
    pd_oe_n             = dir_eff;
    host_strobe_pin     = !dcr_reg[0];
    auto_feed_pin       = !dcr_reg[1];
    reverse_request_out = dcr_reg[2]; // RULE_21
    select_in_pin       = !dcr_reg[3];
    if (epp_reg != EPP_IDLE)
    begin
      pd_oe_n         = !epp_wr_reg; // RULE_01 RULE_08
      host_strobe_pin = !epp_wr_reg; // RULE_05
      auto_feed_pin   = !(epp_reg == EPP_STROBE && !epp_addr_reg); // RULE_06
      select_in_pin   = !(epp_reg == EPP_STROBE && epp_addr_reg); // RULE_02
    end
    else if (mode_reg == MODE_ECP)
    begin
      select_in_pin   = 1'b1; // RULE_22
      host_strobe_pin = (ecp_reg != ECP_FWD_STB);
      if (!dir_eff)
        auto_feed_pin = !cur_reg.tag; // RULE_17
      else
        auto_feed_pin = (ecp_reg != ECP_REV_REQ); // RULE_17
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  property p_read_float;
    @(posedge clk) disable iff (!reset_n)
      (epp_reg != EPP_IDLE && !epp_wr_reg) |-> pd_oe_n;
  endproperty
  a_read_float: assert property (p_read_float) else $error("PD driven in EPP read"); // RULE_08

  property p_addr_strobe;
    @(posedge clk) disable iff (!reset_n)
      (epp_reg == EPP_IDLE && rd_rise && epp_loc && host_req.offset == OFF_EPP_ADDR)
      |=> !select_in_pin && pd_oe_n;
  endproperty
  a_addr_strobe: assert property (p_addr_strobe) else $error("No address strobe"); // RULE_01

  property p_write_drive;
    @(posedge clk) disable iff (!reset_n)
      (epp_reg == EPP_IDLE && wr_rise && epp_loc && host_req.offset[2])
      |=> !pd_oe_n && !host_strobe_pin && !auto_feed_pin
          && pd_out_reg == $past(host_req.wdata);
  endproperty
  a_write_drive: assert property (p_write_drive) else $error("EPP write not driven"); // RULE_04

  property p_data_strobe_release;
    @(posedge clk) disable iff (!reset_n)
      (epp_reg == EPP_STROBE && epp_wr_reg && !epp_addr_reg && pin_reg.busy)
      |=> auto_feed_pin && !host_strobe_pin && !pd_oe_n && done_reg;
  endproperty
  a_data_strobe_release: assert property (p_data_strobe_release) else $error("Data strobe held"); // RULE_06

  property p_write_end;
    @(posedge clk) disable iff (!reset_n)
      (epp_reg == EPP_END && epp_wr_reg && pin_reg.busy && !timed_out)
      |=> !host_strobe_pin;
  endproperty
  a_write_end: assert property (p_write_end) else $error("Write strobe early"); // RULE_07

  property p_read_capture;
    @(posedge clk) disable iff (!reset_n)
      (epp_reg == EPP_STROBE && !epp_wr_reg && pin_reg.busy)
      |=> rdata_reg == $past(pd_reg) && done_reg;
  endproperty
  a_read_capture: assert property (p_read_capture) else $error("Read byte lost"); // RULE_09

  property p_timeout;
    @(posedge clk) disable iff (!reset_n)
      (epp_reg == EPP_STROBE && timed_out && !pin_reg.busy)
      |=> cycle_timeout_flag_reg && epp_reg == EPP_IDLE;
  endproperty
  a_timeout: assert property (p_timeout) else $error("Timeout not flagged"); // RULE_23

  property p_select_in_pin_ecp;
    @(posedge clk) disable iff (!reset_n)
      (mode_reg == MODE_ECP && epp_reg == EPP_IDLE) |-> select_in_pin;
  endproperty
  a_select_in_pin_ecp: assert property (p_select_in_pin_ecp) else $error("Select-in low in ECP"); // RULE_22

  property p_spp_out;
    @(posedge clk) disable iff (!reset_n)
      (mode_reg == MODE_SPP && epp_reg == EPP_IDLE) |-> !pd_oe_n;
  endproperty
  a_spp_out: assert property (p_spp_out) else $error("PD not driven in 000"); // RULE_24

  property p_fifo_flags;
    @(posedge clk) disable iff (!reset_n)
      (epp_reg == EPP_IDLE && rd_rise && host_req.base2 && host_req.offset == OFF_CONTROL)
      |=> rdata_reg[1:0] == {!$past(f_in_ready), !$past(f_out_valid)};
  endproperty
  a_fifo_flags: assert property (p_fifo_flags) else $error("FIFO flags wrong"); // RULE_26
endmodule // epp_ecp_parallel_port

// [hdl/epp_ecp_pkg.sv]
// Operation
// RULE_01: EPP address read floats PD, then asserts address strobe on read strobe.
// RULE_02: Peripheral releases WAIT#; device drops address strobe and latches PD.
// RULE_03: Peripheral floats PD before reasserting WAIT# to close address read.
// RULE_04: Host write to EPP data offsets four to seven drives the byte on PD.
// RULE_05: EPP data write asserts write strobe and data strobe on write strobe.
// RULE_06: WAIT# released: data strobe drops while written byte stays on PD.
// RULE_07: Peripheral reasserts WAIT#, then device drops the write strobe.
// RULE_08: EPP data read floats PD and asserts data strobe on read strobe.
// RULE_09: Peripheral releases WAIT#; device drops data strobe and latches PD.
// RULE_10: Peripheral stops driving PD before reasserting WAIT# after data read.
// RULE_11: One sixteen-byte FIFO serves forward and reverse extended transfers.
// RULE_12: Received run-length counts are expanded; no compression, capability bit clear.
// RULE_13: Address FIFO bytes are tagged; bit 7 selects address or count.
// RULE_14: Mode codes 000,001,010,011,110,111 select the port behaviours.
// RULE_15: Extended control holds mode, fault disable, DMA, service, full, empty.
// RULE_16: Peripheral busy paces forward strobes and flags command in reverse.
// RULE_17: Host acknowledge requests reverse bytes and flags command when forward.
// RULE_18: Forward bytes go out with host strobe handshaking against busy.
// RULE_19: Peripheral drives paper error low to hand PD back to host; the code starts reverse transfers only while it is low.
// RULE_20: Peripheral may pull fault low to request a reverse transfer.
// RULE_21: Reverse request low turns bus; peripheral drives only with select high.
// RULE_22: Select-in output stays high throughout extended capabilities mode; the code drops it for an EPP address strobe.
// RULE_23: EPP handshake unfinished in ten milliseconds aborts and sets timeout flag.
// RULE_24: Direction bit selects output low, input high; forced low in 000; the code also forces it low in 010.
// RULE_25: Extended control top three bits are read/write and select the mode.
// RULE_26: FIFO full and empty bits show the FIFO occupancy.
package epp_ecp_pkg;
  localparam logic [2:0] OFF_DATA     = 3'h0;
  localparam logic [2:0] OFF_STATUS   = 3'h1;
  localparam logic [2:0] OFF_CONTROL  = 3'h2;
  localparam logic [2:0] OFF_EPP_ADDR = 3'h3;
  localparam logic [2:0] MODE_SPP     = 3'h0;
  localparam logic [2:0] MODE_PS2     = 3'h1;
  localparam logic [2:0] MODE_FIFO    = 3'h2;
  localparam logic [2:0] MODE_ECP     = 3'h3;
  localparam logic [2:0] MODE_TEST    = 3'h6;
  localparam logic [2:0] MODE_CFG     = 3'h7;
  localparam int         DCR_DIR      = 5;
  localparam int         ECR_MODE_LSB = 5;
  localparam logic [5:0] DCR_RESET    = 6'h00;
  localparam logic [2:0] ECR_MODE_RST = 3'h0;
  localparam logic [2:0] ECR_CTRL_RST = 3'h1;
  localparam logic [7:0] CAPA_VALUE   = 8'h10;
  localparam logic [7:0] CAPB_VALUE   = 8'h00;
  localparam logic [7:0] DATA_RESET   = 8'h00;
  localparam int         FIFO_DEPTH   = 16;
  localparam int         TIMEOUT_MS   = 10;
  localparam int         CLK_KHZ      = 200000;
  localparam int         TIMEOUT_CYC  = TIMEOUT_MS * CLK_KHZ;

  typedef struct packed {
    logic       base2;
    logic [2:0] offset;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic busy;
    logic ack_n;
    logic perror;
    logic select;
    logic fault_n;
  } pins_t;

  typedef struct packed {
    logic       tag;
    logic [7:0] data;
  } fifo_word_t;

  typedef enum logic [1:0] {EPP_IDLE, EPP_STROBE, EPP_END} epp_state_t;
  typedef enum logic [2:0] {ECP_IDLE, ECP_FWD_STB, ECP_FWD_WAIT,
                            ECP_REV_REQ, ECP_REV_ACK, ECP_REV_PUSH} ecp_state_t;
endpackage

// [tb/epp_ecp_parallel_port_test.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, ob) begin n_checks++; if ((ob) !== (ex)) begin failures++; \
  $display("mismatch %s exp %h got %h", nm, ex, ob); end end
module epp_ecp_parallel_port_test;
  import epp_ecp_pkg::*;
  logic       clk = 1'b0, reset_n = 1'b0, epp_enable = 1'b0, rd_s = 1'b0, wr_s = 1'b0;
  logic       ecp = 1'b0, stall = 1'b0, rev_req;
  logic [3:0] lat = 4'h2;
  logic [7:0] rd_byte = 8'h3C, rdata_reg, pd_out_reg, pd_wire, got, n_rx, r, n0;
  logic       done_reg, pd_oe_n, host_strobe_pin, auto_feed_pin, select_in_pin, busy, got_tag_n;
  host_req_t  host_req = '0;
  pins_t      pins;
  int         failures = 0;
  int         n_checks = 0;
  assign pins = {busy, 4'b1011};
  always #2.5 clk = ~clk;

  epp_ecp_parallel_port #(.TIMEOUT(50)) u_epp_ecp_parallel_port (.clk(clk), .reset_n(reset_n),
    .epp_enable(epp_enable), .host_req(host_req), .internal_read_strobe(rd_s),
    .internal_write_strobe(wr_s), .rdata_reg(rdata_reg), .done_reg(done_reg), .pd_in(pd_wire),
    .pd_out_reg(pd_out_reg), .pd_oe_n(pd_oe_n), .pins_in(pins), .host_strobe_pin(host_strobe_pin),
    .auto_feed_pin(auto_feed_pin), .select_in_pin(select_in_pin), .reverse_request_out(rev_req));
  parallel_peripheral_model u_parallel_peripheral_model (.clk(clk), .ecp(ecp), .stall(stall),
    .lat(lat), .rd_byte(rd_byte), .host_strobe_pin(host_strobe_pin), .auto_feed_pin(auto_feed_pin),
    .select_in_pin(select_in_pin), .pd_oe_n(pd_oe_n), .pd_out_reg(pd_out_reg), .pd_wire(pd_wire),
    .busy(busy), .got(got), .got_tag_n(got_tag_n), .n_rx(n_rx));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic start(input logic rd, input logic b2, input logic [2:0] off, input logic [7:0] wd);
    host_req = {b2, off, wd};
    rd_s = rd;
    wr_s = !rd;
    @(posedge clk);
    #1;
  endtask

  task automatic finish();
    repeat (200)
    begin
      if (done_reg === 1'b1)
        break;
      @(posedge clk);
      #1;
    end
    `CHK("done", 1'b1, done_reg)
    r = rdata_reg;
    rd_s = 1'b0;
    wr_s = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic acc(input logic rd, input logic b2, input logic [2:0] off, input logic [7:0] wd);
    start(rd, b2, off, wd);
    finish();
  endtask

  task automatic wait_rx(input logic [7:0] n);
    repeat (500)
    begin
      if (n_rx === n)
        break;
      @(posedge clk);
      #1;
    end
    `CHK("rx count", n, n_rx)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    acc(1, 1, 3'h2, 8'h00);
    `CHK("ecr", 8'h05, r)
    acc(1, 0, 3'h2, 8'h00);
    `CHK("dcr", 8'hC0, r)
    `CHK("reverse req", 1'b0, rev_req)
    acc(0, 0, 3'h2, 8'h04);
    `CHK("reverse req", 1'b1, rev_req)
    acc(1, 1, 3'h5, 8'h00);
    `CHK("unmapped", 8'hFF, r)
  endtask

  task automatic t_epp_write();
    epp_enable = 1'b1;
    start(0, 0, 3'h5, 8'hA5);
    @(posedge clk);
    #1;
    `CHK("wr strobes", 3'b000, {host_strobe_pin, auto_feed_pin, pd_oe_n})
    `CHK("wr pd", 8'hA5, pd_out_reg)
    finish();
    `CHK("wr hold", 3'b010, {host_strobe_pin, auto_feed_pin, pd_oe_n})
    `CHK("wr hold pd", 8'hA5, pd_out_reg)
    repeat (40)
      if (!host_strobe_pin)
        @(posedge clk);
    #1;
    `CHK("wr end", 1'b1, host_strobe_pin)
    `CHK("wr byte", 8'hA5, got)
  endtask

  task automatic t_epp_read(input logic [2:0] off, input logic [7:0] v);
    rd_byte = v;
    start(1, 0, off, 8'h00);
    @(posedge clk);
    #1;
    `CHK("rd float", 1'b1, pd_oe_n)
    `CHK("rd strobe", (off == 3'h3) ? 2'b10 : 2'b01, {auto_feed_pin, select_in_pin})
    finish();
    `CHK("rd data", v, r)
    `CHK("rd release", 2'b11, {auto_feed_pin, select_in_pin})
    // Once the peripheral closes the cycle the device drives PD again
    repeat (40)
    begin
      if (busy === 1'b0)
        break;
      @(posedge clk);
      #1;
    end
    repeat (4) @(posedge clk);
    #1;
    `CHK("rd idle", 1'b0, pd_oe_n)
  endtask

  task automatic t_timeout();
    stall = 1'b1;
    acc(0, 0, 3'h4, 8'h11);
    stall = 1'b0;
    acc(1, 0, 3'h1, 8'h00);
    `CHK("cycle_timeout_flag set", 8'hDF, r)
    acc(0, 0, 3'h1, 8'h01);
    acc(1, 0, 3'h1, 8'h00);
    `CHK("cycle_timeout_flag clr", 8'hDE, r)
  endtask

  task automatic t_modes();
    logic [2:0] m [6] = '{MODE_SPP, MODE_PS2, MODE_FIFO, MODE_ECP, MODE_TEST, MODE_CFG};
    epp_enable = 1'b0;
    foreach (m[i])
    begin
      acc(0, 1, 3'h2, {m[i], 5'h04});
      acc(1, 1, 3'h2, 8'h00);
      `CHK("ecr mode", {m[i], 5'h05}, r)
    end
    acc(1, 1, 3'h0, 8'h00);
    `CHK("cap a", 8'h10, r)
    acc(1, 1, 3'h1, 8'h00);
    `CHK("cap b", 8'h00, r)
  endtask

  task automatic t_ecp();
    ecp = 1'b1;
    lat = 4'h0;
    acc(0, 1, 3'h2, 8'h64);
    `CHK("select in", 1'b1, select_in_pin)
    n0 = n_rx;
    acc(0, 0, 3'h0, 8'h85);
    wait_rx(n0 + 8'h1);
    `CHK("addr byte", 9'h085, {got_tag_n, got})
    acc(0, 1, 3'h0, 8'h42);
    wait_rx(n0 + 8'h2);
    `CHK("data byte", 9'h142, {got_tag_n, got})
    // Last byte still owns the wire, so sixteen fill the FIFO and one is refused
    stall = 1'b1;
    for (int i = 0; i < 17; i++)
      acc(0, 1, 3'h0, 8'(i));
    acc(1, 1, 3'h2, 8'h00);
    `CHK("ecr full", 8'h66, r)
    stall = 1'b0;
    wait_rx(n0 + 8'd18);
    `CHK("last byte", 8'h0F, got)
    acc(1, 1, 3'h2, 8'h00);
    `CHK("ecr empty", 8'h65, r)
    acc(0, 1, 3'h2, 8'hC4);
    acc(0, 1, 3'h0, 8'h5A);
    acc(1, 1, 3'h0, 8'h00);
    `CHK("test fifo", 8'h5A, r)
    acc(1, 1, 3'h0, 8'h00);
    `CHK("test empty", 8'h5A, r)
  endtask

  task automatic summarize();
    if (failures == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    #1;
    reset_n = 1'b1;
    t_regs();
    t_epp_write();
    t_epp_read(3'h3, 8'h3C);
    t_epp_read(3'h6, 8'hC3);
    t_timeout();
    t_modes();
    t_ecp();
    summarize();
  end

  // Whole run needs a few hundred cycles
  initial
  begin
    #60000;
    failures++;
    summarize();
  end
endmodule // epp_ecp_parallel_port_test

// [tb/parallel_peripheral_model.sv]
`timescale 1ns/1ps
module parallel_peripheral_model
(
  input  wire logic       clk,
  input  wire logic       ecp,
  input  wire logic       stall,
  input  wire logic [3:0] lat,
  input  wire logic [7:0] rd_byte,
  input  wire logic       host_strobe_pin,
  input  wire logic       auto_feed_pin,
  input  wire logic       select_in_pin,
  input  wire logic       pd_oe_n,
  input  wire logic [7:0] pd_out_reg,
  output logic [7:0]      pd_wire,
  output logic            busy,
  output logic [7:0]      got,
  output logic            got_tag_n,
  output logic [7:0]      n_rx
);
  logic       req;
  logic [3:0] cnt;
  // Stall holds busy so the device timeout and FIFO fill can be reached
  assign req = ecp ? !host_strobe_pin : (!auto_feed_pin || !select_in_pin);
  // Released PD shows rd_byte only during a non-ECP request, else its inverse, so a stale byte cannot pass
  assign pd_wire = !pd_oe_n ? pd_out_reg : (req && !ecp) ? rd_byte : ~rd_byte;
  initial {busy, cnt, n_rx} = '0;
  always @(posedge clk)
  begin
    if (req == busy || stall)
      cnt <= '0;
    else if (cnt < lat)
      cnt <= cnt + 4'h1;
    else
    begin
      busy <= req;
      cnt  <= '0;
      if (req)
      begin
        got       <= pd_out_reg;
        got_tag_n <= auto_feed_pin;
        n_rx      <= n_rx + 8'h1;
      end
    end
  end
endmodule // parallel_peripheral_model
